//--- acl_frame_rewrite_stats.sv
`timescale 1ns/1ps
// What this block does
// - each key type used in a lookup sets a sticky flag; writing one clears it.
// - every returned action bumps one of 1024 counters picked by its index, unless software writes that counter in the same cycle.
// - actions may share counters; software writes preset counters, zero clears.
// - first-lookup routed discards count ingress only by mode, never egress.
// - second-lookup routed discards always count ingress, egress only by mode.
// - rewrites show in the ingress mirror copy as well.
// - replace-dmac mode writes replacement mac; command bit 9 limits bit count.
// - swap modes exchange macs; multicast new source takes replacement mac.
// - conditional mac modes swap on unicast dmac, else replace source mac.
// - swap-ip modes exchange ips; multicast new source taken from table.
// - conditional ip mode swaps on unicast dip, else source ip from table.
// - table holds 32 ipv4 or 8 ipv6, indexed by policer index when disabled.
// - ip swap or replace with preset action loads ttl or hop limit.
// - port replace sets l4 ports from match value and mask actions.
// - ipv4 header checksum recomputed; udp updated for ipv6, zeroed for ipv4.
// - local routing sets dmac to next hop and tells rewriter to keep it.
// - local routing sets classified vlan to the egress vlan.
// - local routing may set service instance to egress leg or egress vlan.
// - local routing never decrements ttl or hop limit.
module acl_frame_rewrite_stats #(
   parameter int COUNTERS = acl_pkg::NUM_COUNTERS,
   parameter int CNT_W = 32
) (
   input wire logic hclk, // core clock
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // ahb select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, word only
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic [31:0] hrdata, // ahb read data
   input wire logic lookup_valid, // classifier lookup done
   input wire logic lookup_second, // lookup was the second one
   input wire logic [2:0] key_type, // key type used
   input wire logic action_valid, // classifier returned an action
   input wire logic [9:0] counter_index_action, // counter to bump
   input wire logic discard_valid, // frame discarded by a lookup
   input wire logic discard_second, // discard came from second lookup
   input wire logic discard_routed, // discarded frame was routed
   output logic igr_leg_count, // count in ingress leg stats
   output logic egr_leg_count, // count in egress leg stats
   input wire logic hdr_valid, // header and actions present
   input wire logic [47:0] hdr_dmac, // destination mac
   input wire logic [47:0] hdr_smac, // source mac
   input wire logic hdr_is_ipv4, // ipv4 frame
   input wire logic hdr_is_ipv6, // ipv6 frame
   input wire logic hdr_is_l4, // tcp or udp frame
   input wire logic hdr_is_udp, // udp frame
   input wire logic [127:0] hdr_sip, // source ip, ipv4 in low bits
   input wire logic [127:0] hdr_dip, // destination ip
   input wire logic [7:0] hdr_ttl, // ttl or hop limit
   input wire logic [15:0] hdr_sport, // l4 source port
   input wire logic [15:0] hdr_dport, // l4 destination port
   input wire logic [15:0] hdr_ip_csum, // ipv4 header checksum
   input wire logic [15:0] hdr_udp_csum, // udp checksum
   input wire logic [11:0] hdr_vlan, // classified vlan
   input wire logic [11:0] hdr_vsi, // classified service instance
   input wire logic [4:0] rewrite_mode_action, // address mode, bit 4 routes
   input wire logic [15:0] rewrite_command_action, // rewrite command
   input wire logic [47:0] replacement_mac_action, // replacement mac
   input wire logic policer_enable_action, // policer enable
   input wire logic [4:0] policer_index_action, // policer or table index
   input wire logic hop_preset_enable_action, // preset ttl or hop limit
   input wire logic l4_port_replace_enable, // replace l4 ports
   input wire logic [15:0] match_value_action, // new source port
   input wire logic [15:0] match_value_mask_action, // new destination port
   input wire logic [47:0] next_hop_mac, // next-hop mac
   input wire logic [11:0] egress_vlan, // egress vlan
   input wire logic [11:0] egress_leg, // egress router leg
   output logic out_valid, // rewritten header present
   output logic [47:0] out_dmac, // destination mac
   output logic [47:0] out_smac, // source mac
   output logic [127:0] out_sip, // source ip
   output logic [127:0] out_dip, // destination ip
   output logic [7:0] out_ttl, // ttl or hop limit
   output logic [15:0] out_sport, // l4 source port
   output logic [15:0] out_dport, // l4 destination port
   output logic [15:0] out_ip_csum, // ipv4 header checksum
   output logic [15:0] out_udp_csum, // udp checksum
   output logic [11:0] out_vlan, // classified vlan
   output logic [11:0] out_vsi, // classified service instance
   output logic out_keep_dmac // rewriter must keep dmac
);
   if (COUNTERS < 1 || COUNTERS > acl_pkg::NUM_COUNTERS || CNT_W < 1 || CNT_W > 32)
      $error("acl_frame_rewrite_stats: COUNTERS or CNT_W unsupported");

   // ==========================================
   // bus slave: one wait state on every transfer
   logic [15:0] addr_q;
   logic write_q;
   logic [2*acl_pkg::KEY_TYPES-1:0] key_type_sticky_flags;
   logic [acl_pkg::MISC_W-1:0] classifier_misc_control;
   logic [7:0] hop_preset_value;
   logic [7:0] hop_limit_value;
   logic [5:0] dmac_replace_bit_count;
   logic [31:0] source_ip_table [acl_pkg::SIP_WORDS];
   logic [CNT_W-1:0] match_counter_table [COUNTERS];

   // decode of the held data-phase address
   wire take = hsel & htrans[1] & hready;
   wire wr = ~hreadyout & write_q;
   wire sel_sticky = addr_q == acl_pkg::OFF_STICKY;
   wire sel_misc = addr_q == acl_pkg::OFF_MISC;
   wire sel_swap = addr_q == acl_pkg::OFF_SWAP;
   wire sel_sip = addr_q[15:7] == acl_pkg::OFF_SIP_BASE[15:7];
   wire [9:0] cidx = addr_q[11:2];
   wire sel_cnt = (addr_q[15:12] == acl_pkg::OFF_CNT_BASE[15:12]) & (int'(cidx) < COUNTERS);
   wire [4:0] sidx = addr_q[6:2];
   wire [31:0] cnt_rd = sel_cnt ? 32'(match_counter_table[cidx]) : 32'h00000000;
   wire [31:0] rd_mux = sel_sticky ? 32'(key_type_sticky_flags) :
      sel_misc ? 32'(classifier_misc_control) :
      sel_swap ? {10'h000, dmac_replace_bit_count, hop_limit_value, hop_preset_value} :
      sel_sip ? source_ip_table[sidx] : cnt_rd;

   // address phase capture and data phase answer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         addr_q <= 16'h0000;
         write_q <= 1'b0;
      end
      else if (take && hreadyout)
      begin
         hreadyout <= 1'b0;
         addr_q <= {haddr[15:2], 2'b00};
         write_q <= hwrite;
      end
      else if (!hreadyout)
      begin
         hreadyout <= 1'b1;
         hrdata <= write_q ? 32'h00000000 : rd_mux;
      end
   end

   // ==========================================
   // control registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         classifier_misc_control <= acl_pkg::MISC_RST;
         hop_preset_value <= acl_pkg::TTL_RST;
         hop_limit_value <= acl_pkg::HOP_RST;
         dmac_replace_bit_count <= acl_pkg::DBITS_RST;
      end
      else if (wr && sel_misc)
         classifier_misc_control <= hwdata[acl_pkg::MISC_W-1:0];
      else if (wr && sel_swap)
      begin
         hop_preset_value <= hwdata[acl_pkg::SWAP_TTL_LSB +: 8];
         hop_limit_value <= hwdata[acl_pkg::SWAP_HOP_LSB +: 8];
         dmac_replace_bit_count <= hwdata[acl_pkg::SWAP_DBITS_LSB +: 6];
      end
   end

   wire ingress_leg_stat_mode = classifier_misc_control[acl_pkg::MISC_IGR_STAT];
   wire egress_leg_stat_mode = classifier_misc_control[acl_pkg::MISC_EGR_STAT];
   wire local_routing_select = classifier_misc_control[acl_pkg::MISC_RT_SEL];
   wire vsi_from_egress_leg_enable = classifier_misc_control[acl_pkg::MISC_VSI_LEG];
   wire vsi_from_egress_vlan_enable = classifier_misc_control[acl_pkg::MISC_VSI_VLAN];

   // ==========================================
   // sticky flags, one per lookup and key type; set beats clear
   wire [3:0] set_idx = {lookup_second, key_type};
   wire [2*acl_pkg::KEY_TYPES-1:0] set_vec = lookup_valid ? (16'h0001 << set_idx) : 16'h0000;
   wire [2*acl_pkg::KEY_TYPES-1:0] clr_vec = (wr && sel_sticky) ? hwdata[15:0] : 16'h0000;
   wire [2*acl_pkg::KEY_TYPES-1:0] next_sticky = (key_type_sticky_flags & ~clr_vec) | set_vec;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         key_type_sticky_flags <= 16'h0000;
      else
         key_type_sticky_flags <= next_sticky;
   end

   // source ip table, no reset needed for contents
   always_ff @(posedge hclk)
   begin
      if (wr && sel_sip)
         source_ip_table[sidx] <= hwdata;
   end

   // ==========================================
   // match counters: increment then write, so the write wins
   wire cnt_inc = action_valid & (int'(counter_index_action) < COUNTERS);
   wire cnt_wr = wr & sel_cnt;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < COUNTERS; i++)
            match_counter_table[i] <= '0;
      end
      else
      begin
         if (cnt_inc)
            match_counter_table[counter_index_action] <= match_counter_table[counter_index_action] + 1'b1;
         if (cnt_wr)
            match_counter_table[cidx] <= hwdata[CNT_W-1:0];
      end
   end

   // ==========================================
   // router leg statistics for routed discards
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         igr_leg_count <= 1'b0;
         egr_leg_count <= 1'b0;
      end
      else
      begin
         igr_leg_count <= discard_valid & discard_routed & (discard_second | ingress_leg_stat_mode);
         egr_leg_count <= discard_valid & discard_routed & discard_second & egress_leg_stat_mode;
      end
   end

   // ==========================================
   // mode decode
   wire [3:0] mode = rewrite_mode_action[3:0];
   wire is_ip = hdr_is_ipv4 | hdr_is_ipv6;
   wire dmac_mc = hdr_dmac[acl_pkg::MAC_MC_BIT];
   wire dip_mc = hdr_is_ipv4 ? (hdr_dip[31:28] == 4'hE) : (hdr_dip[127:120] == 8'hFF);
   wire sdip_mc = hdr_is_ipv4 ? (hdr_sip[31:28] == 4'hE) : (hdr_sip[127:120] == 8'hFF);
   wire cond_mac = (mode == acl_pkg::MODE_COND_MAC) | (mode == acl_pkg::MODE_COND_MAC_IP);
   wire swap_mac_all = (mode == acl_pkg::MODE_SWAP_MAC) | (mode == acl_pkg::MODE_SWAP_MAC_IP);
   wire do_swap_mac = swap_mac_all | (cond_mac & ~dmac_mc);
   wire repl_smac = (mode == acl_pkg::MODE_REPL_SMAC) | (mode == acl_pkg::MODE_SMAC_SWAP_IP) | (cond_mac & dmac_mc);
   wire swap_ip_all = (mode == acl_pkg::MODE_SWAP_MAC_IP) | (mode == acl_pkg::MODE_SWAP_IP) |
      (mode == acl_pkg::MODE_SMAC_SWAP_IP);
   wire cond_ip = mode == acl_pkg::MODE_COND_MAC_IP;
   wire do_swap_ip = is_ip & (swap_ip_all | (cond_ip & ~dip_mc));
   wire repl_sip = is_ip & cond_ip & dip_mc;
   wire ip_touched = do_swap_ip | repl_sip;
   wire port_repl = l4_port_replace_enable & hdr_is_l4 & is_ip;
   wire local_route = local_routing_select | rewrite_mode_action[acl_pkg::ROUTE_BIT];

   // table entry; an enabled policer leaves the table unused
   wire [4:0] v6b = {policer_index_action[2:0], 2'b00};
   wire [127:0] tab_ip = hdr_is_ipv4 ? {96'h0, source_ip_table[policer_index_action]} :
      {source_ip_table[v6b], source_ip_table[v6b + 5'd1], source_ip_table[v6b + 5'd2],
       source_ip_table[v6b + 5'd3]};
   wire [47:0] dmask = rewrite_command_action[acl_pkg::DMAC_PARTIAL_BIT] ?
      ~(48'hFFFFFFFFFFFF >> dmac_replace_bit_count) : 48'hFFFFFFFFFFFF;

   // ==========================================
   // header rewrite
   logic [47:0] n_dmac, n_smac;
   logic [127:0] n_sip, n_dip;
   logic [7:0] n_ttl;
   logic [15:0] n_sport, n_dport, n_udp, ip_adj, udp_adj;
   always_comb
   begin
      n_dmac = hdr_dmac;
      n_smac = hdr_smac;
      n_sip = hdr_sip;
      n_dip = hdr_dip;
      n_ttl = hdr_ttl;
      n_sport = hdr_sport;
      n_dport = hdr_dport;
      if (mode == acl_pkg::MODE_REPL_DMAC)
         n_dmac = (replacement_mac_action & dmask) | (hdr_dmac & ~dmask);
      if (do_swap_mac)
      begin
         n_dmac = hdr_smac;
         n_smac = dmac_mc ? replacement_mac_action : hdr_dmac;
      end
      else if (repl_smac)
         n_smac = replacement_mac_action;
      if (do_swap_ip)
      begin
         n_dip = hdr_sip;
         n_sip = (dip_mc && !policer_enable_action) ? tab_ip : hdr_dip;
      end
      else if (repl_sip && !policer_enable_action)
         n_sip = tab_ip;
      if (mode == acl_pkg::MODE_SMAC_SWAP_IP && is_ip && sdip_mc && !policer_enable_action)
         n_dip = hdr_sip;
      if (ip_touched && hop_preset_enable_action)
         n_ttl = hdr_is_ipv4 ? hop_preset_value : hop_limit_value;
      if (port_repl)
      begin
         n_sport = match_value_action;
         n_dport = match_value_mask_action;
      end
      if (local_route)
         n_dmac = next_hop_mac;
   end

   // checksum over ipv4 addresses and ttl word
   ones_adjust #(.WORDS(5)) u_ip_csum (
      .old_sum(hdr_ip_csum),
      .old_words({hdr_sip[31:0], hdr_dip[31:0], hdr_ttl, 8'h00}),
      .new_words({n_sip[31:0], n_dip[31:0], n_ttl, 8'h00}),
      .new_sum(ip_adj)
   );

   // checksum over ipv6 pseudo header addresses and ports
   ones_adjust #(.WORDS(18)) u_udp_csum (
      .old_sum(hdr_udp_csum),
      .old_words({hdr_sip, hdr_dip, hdr_sport, hdr_dport}),
      .new_words({n_sip, n_dip, n_sport, n_dport}),
      .new_sum(udp_adj)
   );

   // udp: zero for ipv4, updated for ipv6 when anything it covers moved
   wire udp_hit = hdr_is_udp & (ip_touched | port_repl);
   assign n_udp = !udp_hit ? hdr_udp_csum : hdr_is_ipv4 ? 16'h0000 :
      (udp_adj == 16'h0000) ? 16'hFFFF : udp_adj;

   // ==========================================
   // registered result; mirror copies are taken from this same stream
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         out_valid <= 1'b0;
         out_dmac <= 48'h000000000000;
         out_smac <= 48'h000000000000;
         out_sip <= '0;
         out_dip <= '0;
         out_ttl <= 8'h00;
         out_sport <= 16'h0000;
         out_dport <= 16'h0000;
         out_ip_csum <= 16'h0000;
         out_udp_csum <= 16'h0000;
         out_vlan <= 12'h000;
         out_vsi <= 12'h000;
         out_keep_dmac <= 1'b0;
      end
      else
      begin
         out_valid <= hdr_valid;
         out_dmac <= n_dmac;
         out_smac <= n_smac;
         out_sip <= n_sip;
         out_dip <= n_dip;
         out_ttl <= n_ttl;
         out_sport <= n_sport;
         out_dport <= n_dport;
         out_ip_csum <= hdr_is_ipv4 ? ip_adj : hdr_ip_csum;
         out_udp_csum <= n_udp;
         out_vlan <= local_route ? egress_vlan : hdr_vlan;
         out_vsi <= !local_route ? hdr_vsi : vsi_from_egress_leg_enable ? egress_leg :
            vsi_from_egress_vlan_enable ? egress_vlan : hdr_vsi;
         out_keep_dmac <= local_route;
      end
   end

   // ==========================================
   // checks
   logic [CNT_W-1:0] cnt_before;
   always_ff @(posedge hclk)
      cnt_before <= match_counter_table[counter_index_action];

   property p_sticky_set;
      @(posedge hclk) disable iff (!hresetn) lookup_valid |=> key_type_sticky_flags[$past(set_idx)];
   endproperty
   a_sticky_set: assert property (p_sticky_set) else $error("sticky flag not set");

   property p_sticky_clr;
      @(posedge hclk) disable iff (!hresetn)
         wr && sel_sticky && hwdata[15:0] == 16'hFFFF && !lookup_valid |=> key_type_sticky_flags == 16'h0000;
   endproperty
   a_sticky_clr: assert property (p_sticky_clr) else $error("sticky flags not cleared");

   property p_cnt_inc;
      @(posedge hclk) disable iff (!hresetn)
         cnt_inc && !cnt_wr |=> match_counter_table[$past(counter_index_action)] == CNT_W'(cnt_before + 1'b1);
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step by one");

   property p_cnt_wr;
      @(posedge hclk) disable iff (!hresetn)
         cnt_wr |=> match_counter_table[$past(cidx)] == $past(hwdata[CNT_W-1:0]);
   endproperty
   a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");

   property p_igr_first;
      @(posedge hclk) disable iff (!hresetn)
         discard_valid && discard_routed && !discard_second |=> !egr_leg_count;
   endproperty
   a_igr_first: assert property (p_igr_first) else $error("first discard counted egress");

   property p_second;
      @(posedge hclk) disable iff (!hresetn)
         discard_valid && discard_routed && discard_second |=> igr_leg_count;
   endproperty
   a_second: assert property (p_second) else $error("second discard not counted ingress");

   property p_route;
      @(posedge hclk) disable iff (!hresetn)
         hdr_valid && local_route |=> out_keep_dmac && out_dmac == $past(next_hop_mac) &&
            out_vlan == $past(egress_vlan);
   endproperty
   a_route: assert property (p_route) else $error("local route not applied");

   property p_ttl_kept;
      @(posedge hclk) disable iff (!hresetn) hdr_valid && !hop_preset_enable_action |=> out_ttl == $past(hdr_ttl);
   endproperty
   a_ttl_kept: assert property (p_ttl_kept) else $error("ttl changed without preset");

   property p_udp4;
      @(posedge hclk) disable iff (!hresetn)
         hdr_valid && hdr_is_ipv4 && hdr_is_udp && port_repl |=> out_udp_csum == 16'h0000;
   endproperty
   a_udp4: assert property (p_udp4) else $error("ipv4 udp checksum not cleared");
endmodule : acl_frame_rewrite_stats

//--- acl_pkg.sv
package acl_pkg;
   // ==========================================
   // register byte offsets on the ahb-lite bus
   localparam logic [15:0] OFF_STICKY = 16'h0000;
   localparam logic [15:0] OFF_MISC = 16'h0004;
   localparam logic [15:0] OFF_SWAP = 16'h0008;
   localparam logic [15:0] OFF_SIP_BASE = 16'h0100;
   localparam logic [15:0] OFF_CNT_BASE = 16'h1000;
   // ==========================================
   // field positions in the misc control register
   localparam int MISC_IGR_STAT = 0;
   localparam int MISC_EGR_STAT = 1;
   localparam int MISC_RT_SEL = 2;
   localparam int MISC_VSI_LEG = 3;
   localparam int MISC_VSI_VLAN = 4;
   localparam int MISC_W = 5;
   // field positions in the swap control register
   localparam int SWAP_TTL_LSB = 0;
   localparam int SWAP_HOP_LSB = 8;
   localparam int SWAP_DBITS_LSB = 16;
   // ==========================================
   // reset values
   localparam logic [4:0] MISC_RST = 5'h00;
   localparam logic [7:0] TTL_RST = 8'h40;
   localparam logic [7:0] HOP_RST = 8'h40;
   localparam logic [5:0] DBITS_RST = 6'h18;
   // ==========================================
   // sizes and positions
   localparam int NUM_COUNTERS = 1024;
   localparam int SIP_WORDS = 32;
   localparam int KEY_TYPES = 8;
   localparam int DMAC_PARTIAL_BIT = 9;
   localparam int MAC_MC_BIT = 40;
   localparam int ROUTE_BIT = 4;
   // ==========================================
   // address rewrite modes in the low four mode bits
   localparam logic [3:0] MODE_NONE = 4'h0;
   localparam logic [3:0] MODE_REPL_DMAC = 4'h1;
   localparam logic [3:0] MODE_REPL_SMAC = 4'h2;
   localparam logic [3:0] MODE_SWAP_MAC = 4'h3;
   localparam logic [3:0] MODE_COND_MAC = 4'h4;
   localparam logic [3:0] MODE_SWAP_MAC_IP = 4'h5;
   localparam logic [3:0] MODE_COND_MAC_IP = 4'h6;
   localparam logic [3:0] MODE_SWAP_IP = 4'h7;
   localparam logic [3:0] MODE_SMAC_SWAP_IP = 4'h8;
endpackage : acl_pkg

//--- ones_adjust.sv
`timescale 1ns/1ps
// ==========================================
// incremental ones-complement checksum update
module ones_adjust #(
   parameter int WORDS = 5
) (
   input wire logic [15:0] old_sum, // checksum before rewrite
   input wire logic [16*WORDS-1:0] old_words, // covered words before
   input wire logic [16*WORDS-1:0] new_words, // covered words after
   output logic [15:0] new_sum // checksum after rewrite
);
   if (WORDS < 1 || WORDS > 1000) $error("ones_adjust: WORDS out of range");

   // add complement of old terms and new terms, then fold carries
   always_comb
   begin
      logic [31:0] acc;
      acc = {16'h0000, ~old_sum};
      for (int i = 0; i < WORDS; i++)
      begin
         acc = acc + {16'h0000, ~old_words[16*i +: 16]} + {16'h0000, new_words[16*i +: 16]};
      end
      acc = {16'h0000, acc[15:0]} + {16'h0000, acc[31:16]};
      acc = {16'h0000, acc[15:0]} + {16'h0000, acc[31:16]};
      new_sum = ~acc[15:0];
   end
endmodule : ones_adjust

//--- rewriter_model.sv
`timescale 1ns/1ps
module rewriter_model (
   input wire logic hclk, // core clock
   input wire logic out_valid, // header present
   input wire logic [47:0] out_dmac, // dmac
   input wire logic [47:0] out_smac, // smac
   input wire logic [7:0] out_ttl, // ttl or hop limit
   input wire logic [11:0] out_vlan, // classified vlan
   input wire logic out_keep_dmac, // keep dmac
   input wire logic igr_leg_count, // ingress leg pulse
   input wire logic egr_leg_count, // egress leg pulse
   output logic [116:0] cap = 117'h0, // last header taken
   output logic [15:0] legs = 16'h0000 // ingress and egress leg counts
);
   // take each header as sent; a kept dmac is never rewritten here
   always @(posedge hclk)
   begin
      legs <= legs + {7'h00, igr_leg_count, 7'h00, egr_leg_count};
      if (out_valid) cap <= {out_keep_dmac, out_vlan, out_ttl, out_smac, out_dmac};
   end
endmodule : rewriter_model

//--- tb_acl_frame_rewrite_stats.sv
`timescale 1ns/1ps
module tb_acl_frame_rewrite_stats;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lookup_valid = 0, lookup_second = 0, action_valid = 0, hresp;
   logic discard_valid = 0, discard_second = 0, discard_routed = 0, hdr_valid = 0, hdr_is_ipv4 = 0, hdr_is_ipv6 = 0;
   logic hdr_is_l4 = 0, hdr_is_udp = 0, policer_enable_action = 0, hop_preset_enable_action = 0, hready, hreadyout;
   logic l4_port_replace_enable = 0, igr_leg_count, egr_leg_count, out_valid, out_keep_dmac;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2, key_type = 0;
   logic [4:0] rewrite_mode_action = 0, policer_index_action = 0;
   logic [7:0] hdr_ttl = 0, out_ttl;
   logic [9:0] counter_index_action = 0;
   logic [11:0] hdr_vlan = 0, hdr_vsi = 0, egress_vlan = 0, egress_leg = 0, out_vlan, out_vsi;
   logic [15:0] hdr_sport = 0, hdr_dport = 0, hdr_ip_csum = 0, hdr_udp_csum = 0, rewrite_command_action = 0, legs;
   logic [15:0] match_value_action = 0, match_value_mask_action = 0, out_sport, out_dport, out_ip_csum, out_udp_csum;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [47:0] hdr_dmac = 0, hdr_smac = 0, replacement_mac_action = 0, next_hop_mac = 0, out_dmac, out_smac;
   logic [127:0] hdr_sip = 0, hdr_dip = 0, out_sip, out_dip;
   logic [116:0] cap;
   int n_mismatch = 0, total_checks = 0;
   // clock, single-slave ready, design and rewriter side
   always #5 hclk = ~hclk;
   assign hready = hreadyout;
   acl_frame_rewrite_stats i_acl_frame_rewrite_stats (.*);
   rewriter_model i_rewriter_model (.*);
   task print_verdict();
      if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task chk(input string nm, input logic [95:0] g, input logic [95:0] e);
      total_checks++;
      if (g !== e) n_mismatch++;
      if (g !== e) $display("[FAIL] %s exp %h got %h", nm, e, g);
   endtask : chk
   task wt();
      for (int n = 0; n == 0 || (hreadyout !== 1'b1 && n < 20); n++) @(posedge hclk);
      chk("ready", hreadyout, 96'h1);
      if (hreadyout !== 1'b1) print_verdict();
   endtask : wt
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
      wt();
      htrans <= 2'h0; hwdata <= d;
      wt();
      rd = hrdata;
      chk("resp", hresp, 96'h0);
   endtask : bus
   task frame(input logic [4:0] m);
      rewrite_mode_action <= m; hdr_valid <= 1'b1;
      @(posedge hclk) hdr_valid <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask : frame
   // counter preset near its top and bumped twice, sticky set and cleared, two routed discards
   task t_events();
      bus(1'b1, 32'h4, 32'hA);
      bus(1'b1, 32'h1014, 32'hFFFF_FFFE);
      action_valid <= 1'b1; counter_index_action <= 10'h005; lookup_valid <= 1'b1; lookup_second <= 1'b1;
      key_type <= 3'h3; discard_routed <= 1'b1; discard_valid <= 1'b1;
      @(posedge hclk) discard_second <= 1'b1;
      @(posedge hclk) {action_valid, lookup_valid, discard_valid} <= 3'h0;
      bus(1'b0, 32'h1014, 32'h0);
      chk("counter", rd, 96'h0);
      chk("legs", legs, 96'h0101);
      bus(1'b0, 32'h0, 32'h0);
      chk("sticky", rd, 96'h800);
      bus(1'b0, 32'h800, 32'h0);
      chk("hole", rd, 96'h0);
      bus(1'b1, 32'h0, 32'hFFFF);
      bus(1'b0, 32'h0, 32'h0);
      chk("cleared", rd, 96'h0);
   endtask : t_events
   // mac swap, conditional mac, ttl preset and local routing on one ipv4 header
   task t_rewrite();
      hdr_dmac <= 48'h0100_0000_0000; hdr_smac <= 48'h55; replacement_mac_action <= 48'hAA; next_hop_mac <= 48'h77;
      hdr_is_ipv4 <= 1'b1; hdr_ttl <= 8'h05; hop_preset_enable_action <= 1'b1; egress_vlan <= 12'h123;
      rewrite_command_action <= 16'h0200;
      egress_leg <= 12'h456;
      frame(5'h03);
      chk("swap", cap[95:0], {48'hAA, 48'h55});
      frame(5'h04);
      chk("cond", cap[95:0], {48'hAA, 48'h0100_0000_0000});
      frame(5'h01);
      chk("partial dmac", cap[95:0], {48'h55, 48'h0});
      frame(5'h07);
      chk("preset", cap[103:96], acl_pkg::TTL_RST);
      hop_preset_enable_action <= 1'b0;
      frame(5'h10);
      chk("route", cap[116:96], {1'b1, 12'h123, 8'h05});
      chk("next hop", cap[47:0], 96'h77);
      chk("route smac", cap[95:48], 96'h55);
      chk("vsi", out_vsi, 96'h456);
   endtask : t_rewrite
   // ipv4 udp frame: multicast dip swaps in a table source ip, ports replaced, checksums fixed
   task t_l4();
      bus(1'b1, 32'h100, 32'h0A00_00FE);
      hdr_sip <= 128'h0A00_0001;
      hdr_dip <= 128'hE000_0001;
      hdr_ip_csum <= 16'h1000;
      hdr_udp_csum <= 16'hBEEF;
      hdr_is_l4 <= 1'b1;
      hdr_is_udp <= 1'b1;
      hop_preset_enable_action <= 1'b1;
      l4_port_replace_enable <= 1'b1;
      match_value_action <= 16'h1234;
      match_value_mask_action <= 16'h5678;
      frame(5'h07);
      chk("new sip", out_sip[95:0], 96'h0A00_00FE);
      chk("new dip", out_dip[95:0], 96'h0A00_0001);
      chk("ports", {out_sport, out_dport}, 96'h1234_5678);
      chk("csums", {out_ip_csum, out_udp_csum}, 96'hAA03_0000);
   endtask : t_l4
   // four reset cycles, then the scenarios
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_events();
      t_rewrite();
      t_l4();
      print_verdict();
   end
endmodule : tb_acl_frame_rewrite_stats
